//--- rtl/bkpt_params.svh
// Constants for the breakpoint compare and instruction tag block.
// Assumes a single 100 MHz core clock and an Avalon-MM register slave.
// How it works
// - Full mode compares data bits 7:0 with low data byte unless masked.
// - One direction compare applies only to the second breakpoint in dual debug mode.
// - Breakpoint one direction value 0 matches writes, 1 matches reads.
// - Zero direction is don't-care in mode 01 and unless its compare enable is set.
// - Breakpoint zero direction value 0 matches writes, 1 matches reads.
// - High address byte compares address bits 15:8 and resets to zero.
// - Low address byte compares only while zero range control is one.
// - High data byte compares data high in full mode, address high in dual.
// - Low data byte compares data or address low, gated by range and mask.
// - Tag enable command turns strobe and serial pins into tag inputs.
// - Tool presents tags valid at E clock fall; device samples then.
// - Tag pins are independent and active low, tagging low or high byte.
// - Tagging works in all modes, stops in debug, blocks serial commands.
// - Tags travel through the queue; tagged head enters background debug.
// - Mode 00 off, 01 dual interrupt, 10 full debug, 11 dual debug.
// - Second compare enable zero keeps data registers out of compares.
`ifndef BKPT_PARAMS_SVH
`define BKPT_PARAMS_SVH
`define BKPT_OFS_CTRL0 8'h20
`define BKPT_OFS_CTRL1 8'h21
`define BKPT_OFS_ADDR_HI 8'h22
`define BKPT_OFS_ADDR_LO 8'h23
`define BKPT_OFS_DATA_HI 8'h24
`define BKPT_OFS_DATA_LO 8'h25
`define BKPT_OFS_IRQ_STAT 8'h26
`define BKPT_OFS_IRQ_CLR 8'h27
`define BKPT_OFS_IRQ_EN 8'h28
`define BKPT_OFS_TAG_CMD 8'h29
`define BKPT_RESET_BYTE 8'h00
`define BKPT_C0_MODE_HI 7
`define BKPT_C0_MODE_LO 6
`define BKPT_C0_ZERO_RANGE 0
`define BKPT_C0_ONE_RANGE 1
`define BKPT_C1_SECOND_EN 6
`define BKPT_C1_HIGH_MASK 5
`define BKPT_C1_LOW_MASK 4
`define BKPT_C1_ONE_DIR_EN 3
`define BKPT_C1_ONE_DIR_VAL 2
`define BKPT_C1_ZERO_DIR_EN 1
`define BKPT_C1_ZERO_DIR_VAL 0
`define BKPT_IRQ_ZERO 0
`define BKPT_IRQ_ONE 1
`define BKPT_IRQ_TAG 2
`define BKPT_CMD_TAG_GO 0
`define BKPT_CMD_TAG_STOP 1
`endif

//--- rtl/bkpt_pkg.sv
// Types shared by the breakpoint compare and tag files.
// Assumes the params header is included by the design files.
package bkpt_pkg;
    typedef enum logic [1:0] {
        BKPT_MODE_OFF,
        BKPT_MODE_DUAL_IRQ,
        BKPT_MODE_FULL_DBG,
        BKPT_MODE_DUAL_DBG
    } bkpt_mode_type;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
        logic read;
    } bkpt_cycle_type;

    typedef struct packed {
        logic [15:0] bytes;
        logic [1:0] tag;
    } bkpt_queue_type;
endpackage

//--- rtl/bkpt_sync.sv
// Two flip-flop synchroniser for one pin level.
// Assumes the input is asynchronous to i_core_clk.
`timescale 1ns/1ps
module bkpt_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Level
    input wire logic i_level,
    output logic o_level
);
    logic stage_reg;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage_reg <= RESET_VALUE;
            o_level <= RESET_VALUE;
        end else begin
            stage_reg <= i_level;
            o_level <= stage_reg;
        end
    end
endmodule

//--- rtl/bkpt_top.sv
// Breakpoint comparator, tag sampling and tagged instruction queue.
// Assumes a registered CPU cycle strobe and a pin-level E clock.
`timescale 1ns/1ps
`include "bkpt_params.svh"
module bkpt_top #(
    parameter int QUEUE_DEPTH = 3
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Avalon-MM slave
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [7:0] i_writedata,
    output logic [7:0] o_readdata,
    output logic o_waitrequest,
    // CPU bus cycle
    input wire bkpt_pkg::bkpt_cycle_type i_cycle,
    // Program fetch into the queue and instruction issue
    input wire logic i_fetch_valid,
    input wire logic [15:0] i_fetch_bytes,
    input wire logic i_issue,
    output logic o_head_valid,
    output logic [15:0] o_head_bytes,
    // Background debug state and serial command
    input wire logic i_background_debug_mode,
    input wire logic i_serial_cmd_valid,
    output logic o_serial_cmd_accept,
    // Shared pins
    input wire logic i_bus_e_clock,
    input wire logic i_low_byte_strobe_pin,
    input wire logic i_debug_serial_pin,
    // Results
    output logic o_software_interrupt,
    output logic o_enter_background_debug,
    output logic o_tag_active,
    output logic o_irq
);
    import bkpt_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctrl0_reg;
    logic [7:0] ctrl1_reg;
    logic [7:0] break_address_high_reg;
    logic [7:0] break_address_low_reg;
    logic [7:0] break_data_high_reg;
    logic [7:0] break_data_low_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_en_reg;
    logic tag_active_reg;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic rd_ack_reg;
    logic wr_ok;

    // Reads take one wait cycle so read data come from a flip-flop.
    assign o_waitrequest = i_read && !rd_ack_reg;
    assign wr_ok = i_write;
    assign irq_clr = (wr_ok && i_address == `BKPT_OFS_IRQ_CLR)
        ? i_writedata[2:0] : 3'h0;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl0_reg <= `BKPT_RESET_BYTE;
            ctrl1_reg <= `BKPT_RESET_BYTE;
            break_address_high_reg <= `BKPT_RESET_BYTE;
            break_address_low_reg <= `BKPT_RESET_BYTE;
            break_data_high_reg <= `BKPT_RESET_BYTE;
            break_data_low_reg <= `BKPT_RESET_BYTE;
            irq_en_reg <= 3'h0;
        end else if (wr_ok) begin
            if (i_address == `BKPT_OFS_CTRL0) begin
                ctrl0_reg <= i_writedata;
            end else if (i_address == `BKPT_OFS_CTRL1) begin
                ctrl1_reg <= {1'b0, i_writedata[6:0]};
            end else if (i_address == `BKPT_OFS_ADDR_HI) begin
                break_address_high_reg <= i_writedata;
            end else if (i_address == `BKPT_OFS_ADDR_LO) begin
                break_address_low_reg <= i_writedata;
            end else if (i_address == `BKPT_OFS_DATA_HI) begin
                break_data_high_reg <= i_writedata;
            end else if (i_address == `BKPT_OFS_DATA_LO) begin
                break_data_low_reg <= i_writedata;
            end else if (i_address == `BKPT_OFS_IRQ_EN) begin
                irq_en_reg <= i_writedata[2:0];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_ack_reg <= 1'b0;
            o_readdata <= 8'h00;
        end else begin
            rd_ack_reg <= i_read && !rd_ack_reg;
            if (i_read && !rd_ack_reg) begin
                if (i_address == `BKPT_OFS_CTRL0) begin
                    o_readdata <= ctrl0_reg;
                end else if (i_address == `BKPT_OFS_CTRL1) begin
                    o_readdata <= ctrl1_reg;
                end else if (i_address == `BKPT_OFS_ADDR_HI) begin
                    o_readdata <= break_address_high_reg;
                end else if (i_address == `BKPT_OFS_ADDR_LO) begin
                    o_readdata <= break_address_low_reg;
                end else if (i_address == `BKPT_OFS_DATA_HI) begin
                    o_readdata <= break_data_high_reg;
                end else if (i_address == `BKPT_OFS_DATA_LO) begin
                    o_readdata <= break_data_low_reg;
                end else if (i_address == `BKPT_OFS_IRQ_STAT) begin
                    o_readdata <= {5'h00, irq_stat_reg};
                end else if (i_address == `BKPT_OFS_IRQ_EN) begin
                    o_readdata <= {5'h00, irq_en_reg};
                end else if (i_address == `BKPT_OFS_TAG_CMD) begin
                    o_readdata <= {7'h00, tag_active_reg};
                end else begin
                    o_readdata <= 8'h00;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Breakpoint compare
    // ------------------------------------------------------------
    bkpt_mode_type mode;
    logic dual_mode;
    logic second_en;
    logic hi0_hit;
    logic lo0_hit;
    logic dir0_hit;
    logic dhi_hit;
    logic dlo_hit;
    logic dir1_hit;
    logic bp0_hit;
    logic bp1_hit;
    logic any_hit;
    logic bp0_reg;
    logic bp1_reg;

    assign mode = bkpt_mode_type'(
        ctrl0_reg[`BKPT_C0_MODE_HI:`BKPT_C0_MODE_LO]);
    assign dual_mode = (mode == BKPT_MODE_DUAL_IRQ)
        || (mode == BKPT_MODE_DUAL_DBG);
    assign second_en = ctrl1_reg[`BKPT_C1_SECOND_EN];
    assign hi0_hit = i_cycle.addr[15:8] == break_address_high_reg;
    assign lo0_hit = !ctrl0_reg[`BKPT_C0_ZERO_RANGE]
        || (i_cycle.addr[7:0] == break_address_low_reg);
    // Interrupt dual mode ignores direction, as its breaks are fetch only.
    assign dir0_hit = (mode == BKPT_MODE_DUAL_IRQ)
        || !ctrl1_reg[`BKPT_C1_ZERO_DIR_EN]
        || (i_cycle.read == ctrl1_reg[`BKPT_C1_ZERO_DIR_VAL]);
    assign dir1_hit = (mode == BKPT_MODE_DUAL_IRQ)
        || !ctrl1_reg[`BKPT_C1_ONE_DIR_EN]
        || (i_cycle.read == ctrl1_reg[`BKPT_C1_ONE_DIR_VAL]);
    always_comb begin
        if (dual_mode) begin
            dhi_hit = i_cycle.addr[15:8] == break_data_high_reg;
            dlo_hit = !ctrl0_reg[`BKPT_C0_ONE_RANGE]
                || (i_cycle.addr[7:0] == break_data_low_reg);
        end else begin
            dhi_hit = !second_en || ctrl1_reg[`BKPT_C1_HIGH_MASK]
                || (i_cycle.data[15:8] == break_data_high_reg);
            dlo_hit = !second_en || ctrl1_reg[`BKPT_C1_LOW_MASK]
                || (i_cycle.data[7:0] == break_data_low_reg);
        end
    end
    assign bp0_hit = (mode != BKPT_MODE_OFF) && hi0_hit && lo0_hit
        && dir0_hit && (dual_mode || (dhi_hit && dlo_hit));
    assign bp1_hit = dual_mode && second_en && dhi_hit && dlo_hit
        && dir1_hit;
    assign any_hit = i_cycle.valid && !i_background_debug_mode;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bp0_reg <= 1'b0;
            bp1_reg <= 1'b0;
        end else begin
            bp0_reg <= any_hit && bp0_hit;
            bp1_reg <= any_hit && bp1_hit;
        end
    end

    // ------------------------------------------------------------
    // Tag pins and instruction queue
    // ------------------------------------------------------------
    logic eclock_s;
    logic tag_low_s;
    logic tag_high_s;
    logic eclock_d_reg;
    logic eclock_fall;
    logic [1:0] tag_latch_reg;
    logic tag_cmd_go;
    bkpt_queue_type queue_reg [QUEUE_DEPTH];
    logic [QUEUE_DEPTH-1:0] qvalid_reg;
    logic head_tagged;

    bkpt_sync #(.RESET_VALUE(1'b0)) u_sync_eclock (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_level(i_bus_e_clock),
        .o_level(eclock_s)
    );
    bkpt_sync #(.RESET_VALUE(1'b1)) u_sync_tag_low (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_level(i_low_byte_strobe_pin),
        .o_level(tag_low_s)
    );
    bkpt_sync #(.RESET_VALUE(1'b1)) u_sync_tag_high (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_level(i_debug_serial_pin),
        .o_level(tag_high_s)
    );

    assign eclock_fall = eclock_d_reg && !eclock_s;
    assign tag_cmd_go = wr_ok && (i_address == `BKPT_OFS_TAG_CMD)
        && i_writedata[`BKPT_CMD_TAG_GO];
    // A serial command is refused while the tag pins are claimed.
    assign o_serial_cmd_accept = i_serial_cmd_valid
        && !tag_active_reg;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tag_active_reg <= 1'b0;
        end else if (i_background_debug_mode) begin
            tag_active_reg <= 1'b0;
        end else if (tag_cmd_go) begin
            tag_active_reg <= 1'b1;
        end else if (wr_ok && i_address == `BKPT_OFS_TAG_CMD
                && i_writedata[`BKPT_CMD_TAG_STOP]) begin
            tag_active_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            eclock_d_reg <= 1'b0;
            tag_latch_reg <= 2'b00;
        end else begin
            eclock_d_reg <= eclock_s;
            if (eclock_fall) begin
                tag_latch_reg <= tag_active_reg
                    ? {~tag_high_s, ~tag_low_s} : 2'b00;
            end
        end
    end

    // Fetch appends at the tail; issue pops the head; a full queue drops.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            qvalid_reg <= '0;
            for (int i = 0; i < QUEUE_DEPTH; i++) begin
                queue_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < QUEUE_DEPTH; i++) begin
                if (i_issue && qvalid_reg[0]) begin
                    if (i == QUEUE_DEPTH - 1) begin
                        qvalid_reg[i] <= 1'b0;
                    end else begin
                        qvalid_reg[i] <= qvalid_reg[i+1];
                        queue_reg[i] <= queue_reg[i+1];
                    end
                end
            end
            if (i_fetch_valid) begin
                for (int i = QUEUE_DEPTH - 1; i >= 0; i--) begin
                    if (!qvalid_reg[i] || (i_issue && qvalid_reg[0]
                            && i == QUEUE_DEPTH - 1)) begin
                    end
                end
            end
            if (i_fetch_valid) begin
                for (int i = 0; i < QUEUE_DEPTH; i++) begin
                    if (!qvalid_reg[i] && (i == 0 || qvalid_reg[i-1])) begin
                        if (i_issue && qvalid_reg[0] && i > 0) begin
                            queue_reg[i-1] <= {i_fetch_bytes, tag_latch_reg};
                            qvalid_reg[i-1] <= 1'b1;
                        end else if (!(i_issue && qvalid_reg[0])) begin
                            queue_reg[i] <=
                                {i_fetch_bytes, tag_latch_reg};
                            qvalid_reg[i] <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    assign head_tagged = qvalid_reg[0] && (queue_reg[0].tag != 2'b00);
    assign o_head_valid = qvalid_reg[0] && !head_tagged;
    assign o_head_bytes = queue_reg[0].bytes;
    assign o_tag_active = tag_active_reg;

    // ------------------------------------------------------------
    // Outcomes and interrupt
    // ------------------------------------------------------------
    assign o_enter_background_debug = (head_tagged
        || ((bp0_reg || bp1_reg) && mode != BKPT_MODE_DUAL_IRQ))
        && !i_background_debug_mode;
    assign o_software_interrupt = (bp0_reg || bp1_reg)
        && mode == BKPT_MODE_DUAL_IRQ;
    assign irq_set = {head_tagged, bp1_reg, bp0_reg};

    // Set wins over a clear in the same cycle.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_stat_reg <= 3'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end
    assign o_irq = |(irq_stat_reg & irq_en_reg);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_break_needs_cycle: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        (bp0_reg || bp1_reg) |-> $past(i_cycle.valid)
            && !$past(i_background_debug_mode))
        else $error("Breakpoint without a valid non-debug cycle.");
    a_off_no_break: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        $past(mode) == BKPT_MODE_OFF |-> !bp0_reg && !bp1_reg)
        else $error("Breakpoint raised while off.");
    a_second_gated: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        !$past(second_en) |-> !bp1_reg)
        else $error("Second breakpoint without its enable.");
    a_addr_high_cmp: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        bp0_reg |-> $past(i_cycle.addr[15:8]) == $past(break_address_high_reg))
        else $error("High address byte mismatch on break.");
    a_dir0_write: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        bp0_reg && $past(mode) == BKPT_MODE_FULL_DBG
            && $past(ctrl1_reg[1])
            |-> $past(i_cycle.read) == $past(ctrl1_reg[0]))
        else $error("Direction compare of breakpoint zero broken.");
    a_data_low_cmp: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        bp0_reg && $past(mode) == BKPT_MODE_FULL_DBG && $past(second_en)
            && !$past(ctrl1_reg[4])
            |-> $past(i_cycle.data[7:0]) == $past(break_data_low_reg))
        else $error("Low data byte mismatch on break.");
    a_tag_cmd_block: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        tag_active_reg |-> !o_serial_cmd_accept)
        else $error("Serial command taken while tagging.");
    a_tag_debug_off: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        i_background_debug_mode |=> !tag_active_reg)
        else $error("Tagging survived background debug.");
    a_tag_head_stop: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        head_tagged && !i_background_debug_mode
            |-> o_enter_background_debug && !o_head_valid)
        else $error("Tagged instruction not stopped.");
    a_tag_latch_idle: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        eclock_fall && !tag_active_reg |=> tag_latch_reg == 2'b00)
        else $error("Tag latched while tagging off.");
    c_soft_int_break: cover property (@(posedge i_core_clk)
        o_software_interrupt);
    c_full_dbg_break: cover property (@(posedge i_core_clk)
        bp0_reg && mode == BKPT_MODE_FULL_DBG);
    c_tag_stop: cover property (@(posedge i_core_clk) head_tagged);
endmodule

//--- test/bkpt_tool_model.sv
// Development tool model: makes the E clock and drives both tag pins.
// Assumes the bench sets the wanted active-low tag levels at any time.
`timescale 1ns/1ps
module bkpt_tool_model (
    // Wanted levels
    input wire logic i_tag_high_n,
    input wire logic i_tag_low_n,
    // Pins
    output logic o_bus_e_clock,
    output logic o_low_byte_strobe_pin,
    output logic o_debug_serial_pin
);
    initial begin
        o_bus_e_clock = 1'b0;
        o_low_byte_strobe_pin = 1'b1;
        o_debug_serial_pin = 1'b1;
    end
    // The E clock is slow and unrelated in phase to the core clock.
    always #43 o_bus_e_clock = !o_bus_e_clock;
    // Levels move at E rise, so they are settled by the following fall.
    always @(posedge o_bus_e_clock) begin
        o_low_byte_strobe_pin <= i_tag_low_n;
        o_debug_serial_pin <= i_tag_high_n;
    end
endmodule

//--- test/breakpoint_compare_and_tagging_tb_top.sv
// Self-checking bench for the breakpoint compare and tag block.
// Assumes the design files and the tool model are compiled before it.
`timescale 1ns/1ps
module breakpoint_compare_and_tagging_tb_top;
    import bkpt_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_address = 8'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [7:0] i_writedata = 8'h00;
    logic [7:0] o_readdata;
    logic o_waitrequest;
    bkpt_cycle_type i_cycle = '0;
    logic i_fetch_valid = 1'b0;
    logic [15:0] i_fetch_bytes = 16'h0000;
    logic i_issue = 1'b0;
    logic o_head_valid, o_serial_cmd_accept, o_software_interrupt;
    logic o_enter_background_debug, o_tag_active, o_irq;
    logic [15:0] o_head_bytes;
    logic i_background_debug_mode = 1'b0;
    logic i_serial_cmd_valid = 1'b0;
    logic e_clk, lo_pin, hi_pin;
    logic tag_hi_n = 1'b1;
    logic tag_lo_n = 1'b1;
    int err_total = 0;
    int check_count = 0;
    int cyc_n = 0;
    integer seed = 32'hC9E6FED5;
    logic [7:0] rv [0:5];
    logic [7:0] en;
    logic [1:0] st;
    logic [1:0] e;
    logic [15:0] fb;
    bkpt_cycle_type cy;

    bkpt_top #(.QUEUE_DEPTH(3)) dut (.i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_cycle(i_cycle), .i_fetch_valid(i_fetch_valid),
        .i_fetch_bytes(i_fetch_bytes), .i_issue(i_issue),
        .o_head_valid(o_head_valid), .o_head_bytes(o_head_bytes),
        .i_background_debug_mode(i_background_debug_mode),
        .i_serial_cmd_valid(i_serial_cmd_valid),
        .o_serial_cmd_accept(o_serial_cmd_accept),
        .i_bus_e_clock(e_clk), .i_low_byte_strobe_pin(lo_pin),
        .i_debug_serial_pin(hi_pin),
        .o_software_interrupt(o_software_interrupt),
        .o_enter_background_debug(o_enter_background_debug),
        .o_tag_active(o_tag_active), .o_irq(o_irq));
    bkpt_tool_model tool (.i_tag_high_n(tag_hi_n), .i_tag_low_n(tag_lo_n),
        .o_bus_e_clock(e_clk), .o_low_byte_strobe_pin(lo_pin),
        .o_debug_serial_pin(hi_pin));

    always #5 i_core_clk = !i_core_clk;
    // Cut a hang short; the full run needs well under this many cycles.
    always @(posedge i_core_clk) begin
        cyc_n++;
        if (cyc_n == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            err_total++;
            $display("BAD t=%0t %s", $time, m);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] r);
        @(posedge i_core_clk);
        i_address <= a;
        i_write <= w;
        i_read <= !w;
        i_writedata <= d;
        do @(posedge i_core_clk); while (o_waitrequest !== 1'b0);
        r = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b0, a, 8'h00, x);
        cmp(x === d, "register read");
    endtask

    // Reference compare: bit 0 is breakpoint zero, bit 1 breakpoint one.
    function automatic logic [1:0] hit(input bkpt_cycle_type c);
        logic [1:0] m;
        logic [1:0] md;
        md = rv[0][7:6];
        m[0] = c.addr[15:8] == rv[2] && (!rv[0][0] || c.addr[7:0] == rv[3]);
        if (md == 2'b10 && rv[1][6])
            m[0] &= (rv[1][5] || c.data[15:8] == rv[4])
                && (rv[1][4] || c.data[7:0] == rv[5]);
        if (md[1] && rv[1][1])
            m[0] &= c.read == rv[1][0];
        m[1] = md[0] && rv[1][6] && c.addr[15:8] == rv[4]
            && (!rv[0][1] || c.addr[7:0] == rv[5]);
        if (md == 2'b11 && rv[1][3])
            m[1] &= c.read == rv[1][2];
        return (md == 2'b00 || i_background_debug_mode) ? 2'b00 : m;
    endfunction

    initial begin
        repeat (20) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        for (int i = 2; i < 6; i++)
            chk(8'h20 + 8'(i), 8'h00);
        chk(8'h40, 8'h00);
        chk(8'h27, 8'h00);
        // --------------------------------------------------------------
        // Compare across all modes, masks, ranges and directions.
        // --------------------------------------------------------------
        for (int k = 0; k < 32; k++) begin
            rv[0] = {2'(k), 4'h0, 2'($random(seed))};
            rv[1] = 8'($random(seed)) & 8'h7F;
            for (int i = 2; i < 6; i++)
                rv[i] = 8'($random(seed));
            en = 8'($random(seed)) & 8'h07;
            @(posedge i_core_clk);
            i_background_debug_mode <= (k % 8 == 7);
            for (int i = 0; i < 6; i++)
                wr(8'h20 + 8'(i), rv[i]);
            for (int i = 1; i < 6; i++)
                chk(8'h20 + 8'(i), rv[i]);
            wr(8'h28, en);
            wr(8'h27, 8'hFF);
            st = 2'b00;
            for (int j = 0; j < 8; j++) begin
                cy.valid = 1'b1;
                cy.read = 1'($random(seed));
                cy.addr = j[0] ? {rv[4], rv[5]} : {rv[2], rv[3]};
                cy.data = {rv[4], rv[5]};
                if ($random(seed) % 3 == 0)
                    cy.addr ^= 16'h0001 << 4'($random(seed));
                if ($random(seed) % 3 == 0)
                    cy.data ^= 16'h0001 << 4'($random(seed));
                @(posedge i_core_clk);
                i_cycle <= cy;
                e = hit(cy);
                st |= e;
                @(posedge i_core_clk);
                i_cycle <= '0;
                #1;
                cmp(o_enter_background_debug === (|e && rv[0][7]),
                    "debug entry");
                cmp(o_software_interrupt === (|e && rv[0][7:6] == 2'b01),
                    "soft interrupt");
            end
            chk(8'h26, {6'h00, st});
            cmp(o_irq === |(st & en[1:0]), "irq level");
            wr(8'h27, 8'hFF);
            @(posedge i_core_clk);
            #1;
            cmp(o_irq === 1'b0, "irq after clear");
        end
        // --------------------------------------------------------------
        // Tagging through the queue for each pin combination.
        // --------------------------------------------------------------
        @(posedge i_core_clk);
        i_background_debug_mode <= 1'b0;
        i_serial_cmd_valid <= 1'b1;
        wr(8'h29, 8'h01);
        @(posedge i_core_clk);
        #1;
        cmp(o_tag_active === 1'b1 && o_serial_cmd_accept === 1'b0,
            "tag start");
        for (int t = 0; t < 4; t++) begin
            {tag_hi_n, tag_lo_n} = ~2'(t);
            repeat (2) @(negedge e_clk);
            repeat (4) @(posedge i_core_clk);
            fb = 16'($random(seed));
            i_fetch_valid <= 1'b1;
            i_fetch_bytes <= fb;
            @(posedge i_core_clk);
            i_fetch_valid <= 1'b0;
            for (int w = 0; w < 10 && o_head_valid !== 1'b1
                 && o_enter_background_debug !== 1'b1; w++)
                @(posedge i_core_clk);
            #1;
            cmp(o_enter_background_debug === (t != 0), "tag head");
            cmp(o_head_valid === (t == 0), "head valid");
            if (t == 0)
                cmp(o_head_bytes === fb, "head bytes");
            @(posedge i_core_clk);
            i_issue <= 1'b1;
            @(posedge i_core_clk);
            i_issue <= 1'b0;
        end
        {tag_hi_n, tag_lo_n} = 2'b11;
        wr(8'h29, 8'h02);
        @(posedge i_core_clk);
        #1;
        cmp(o_tag_active === 1'b0, "tag stop");
        wr(8'h29, 8'h01);
        i_background_debug_mode <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        #1;
        cmp(o_tag_active === 1'b0 && o_serial_cmd_accept === 1'b1,
            "tag stop in debug");
        tally_and_finish();
    end
endmodule
